// ---- hw/mgmt_pkg.sv ----
// constants for the serial management slave port
package mgmt_pkg;
  localparam int unsigned PREAMBLE_ONES   = 32;  // ones needed before a start pattern
  localparam int unsigned PREAMBLE_CNT_W  = 6;
  localparam logic [1:0]  START_PATTERN   = 2'h1;   // 01
  localparam logic [1:0]  OP_READ         = 2'h2;   // 10
  localparam logic [1:0]  OP_WRITE        = 2'h1;   // 01
  localparam int unsigned PHY_ADDR_W      = 5;
  localparam int unsigned REG_ADDR_W      = 5;
  localparam int unsigned DATA_W          = 16;
  localparam int unsigned FIELD_CNT_W     = 5;
  localparam int unsigned READ_DRIVE_BITS = 17;     // turnaround bit two plus data
  // register and bit holding the preamble skip setting
  localparam logic [4:0]  SKIP_REG_ADDR   = 5'h01;
  localparam int unsigned SKIP_BIT        = 6;
endpackage

// ---- hw/mgmt_sync.sv ----
// two flip-flop synchroniser for one level from outside the clock domain
`timescale 1ns/10ps
module mgmt_sync
#(
  parameter logic RESET_VALUE = 1'b1
)
(
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_ff;
  logic sync_ff;

  // first stage is read only by the second
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      meta_ff <= RESET_VALUE;
      sync_ff <= RESET_VALUE;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

// ---- hw/phy_mdio_management_port.sv ----
// serial management slave port: frame decode, register access, data line drive
`timescale 1ns/10ps
// How it works
// - 32 ones precede frame, else ignored
// - preamble skip enable accepts short preamble
// - start pattern 01 marks fields follow
// - opcode 10 reads, 01 writes
// - five-bit transceiver address, MSB first
// - five-bit register index, MSB first
// - read turnaround: float, then drive low
// - sixteen data bits, MSB first
// - read bits change after rising edge
// - device drives exactly last 17 bits
// - port keeps working while isolated
module phy_mdio_management_port
  import mgmt_pkg::*;
#(
  parameter logic [PHY_ADDR_W-1:0] OWN_ADDR = 5'h01
)
(
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  input  wire logic                  mdc,
  input  wire logic                  mdio_in,
  output logic                       mdio_out,
  output logic                       mdio_oe_n,
  input  wire logic                  isolate,
  input  wire logic [DATA_W-1:0]     reg_rd_data,
  output logic [REG_ADDR_W-1:0]      reg_addr,
  output logic                       reg_rd_strobe,
  output logic [DATA_W-1:0]          reg_wr_data,
  output logic                       reg_wr_strobe,
  output logic                       preamble_skip_enable
);

  // ----------------------------------------------------------------
  // link sampling
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_PREAMBLE,
    ST_START,
    ST_OPCODE,
    ST_PHYAD,
    ST_REGAD,
    ST_TURN,
    ST_DATA,
    ST_CLOSE
  } phase_type;

  logic mdc_s;
  logic mdio_s;
  logic mdc_d_ff;

  mgmt_sync #(.RESET_VALUE(1'b0)) u_sync_mdc
  (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .async_in (mdc),
    .sync_out (mdc_s)
  );

  mgmt_sync #(.RESET_VALUE(1'b1)) u_sync_mdio
  (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .async_in (mdio_in),
    .sync_out (mdio_s)
  );

  // limitation: mdc must stay slower than about half of ref_clk,
  // or a short high phase slips between two samples and an edge is lost
  // edges found from the synchronised clock; isolation never gates them
  wire rise = mdc_s & ~mdc_d_ff;

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      mdc_d_ff <= 1'b0;
    else
      mdc_d_ff <= mdc_s;
  end

  // ----------------------------------------------------------------
  // frame state
  // ----------------------------------------------------------------
  // frame registers, all advanced from the detected clock edge except the shift_ff load of read data
  phase_type                 phase_ff;
  phase_type                 nxt_phase;
  logic [PREAMBLE_CNT_W-1:0] ones_ff;
  logic [FIELD_CNT_W-1:0]    cnt_ff;
  logic [1:0]                pair_ff;
  logic                      is_read_ff;
  logic [PHY_ADDR_W-1:0]     phy_ff;
  logic [REG_ADDR_W-1:0]     reg_ff;
  logic [DATA_W-1:0]         shift_ff;
  logic                      mine_ff;
  logic                      skip_ff;

  // preamble counter saturates so long preambles still qualify
  wire preamble_ok = (ones_ff == PREAMBLE_CNT_W'(PREAMBLE_ONES)) | skip_ff;
  wire [1:0] pair_now = {pair_ff[0], mdio_s};
  wire last_field = (cnt_ff == '0);
  wire [PHY_ADDR_W-1:0] phy_now = {phy_ff[PHY_ADDR_W-2:0], mdio_s};
  wire addr_hit = (phy_now == OWN_ADDR);
  wire skip_write = mine_ff & ~is_read_ff & (reg_ff == SKIP_REG_ADDR);

  // next phase on each rising management clock edge, one bit per edge
  always_comb
  begin
    nxt_phase = phase_ff;
    unique case (phase_ff)
      ST_PREAMBLE: if (preamble_ok & ~mdio_s) nxt_phase = ST_START;
      ST_START:    nxt_phase = (pair_now == START_PATTERN) ? ST_OPCODE : ST_PREAMBLE;
      ST_OPCODE:
        if (cnt_ff[0])
          nxt_phase = ((pair_now == OP_READ) | (pair_now == OP_WRITE)) ?
                      ST_PHYAD : ST_PREAMBLE;
      ST_PHYAD:    if (last_field) nxt_phase = ST_REGAD;
      ST_REGAD:    if (last_field) nxt_phase = ST_TURN;
      ST_TURN:     if (cnt_ff[0]) nxt_phase = ST_DATA;
      ST_DATA:     if (last_field) nxt_phase = ST_CLOSE;
      ST_CLOSE:    nxt_phase = ST_PREAMBLE;
    endcase
  end

  // ones counted only while hunting; cleared by any zero
  wire hunting  = (phase_ff == ST_PREAMBLE);
  wire ones_inc = hunting & mdio_s & ~preamble_ok;
  wire ones_clr = ~hunting | ~mdio_s;
  wire [PREAMBLE_CNT_W-1:0] nxt_ones = ones_inc ? ones_ff + 1'b1 :
                                       ones_clr ? '0 : ones_ff;

  // field counter: loaded with the field length less one (zero for two-bit fields) on a phase change;
  // two-bit fields count up and test bit zero, longer ones count down
  wire phase_moves = (phase_ff != nxt_phase);
  wire counts_up   = (phase_ff == ST_OPCODE) | (phase_ff == ST_TURN);
  wire [FIELD_CNT_W-1:0] field_len =
    (nxt_phase == ST_PHYAD) ? FIELD_CNT_W'(PHY_ADDR_W - 1) :
    (nxt_phase == ST_REGAD) ? FIELD_CNT_W'(REG_ADDR_W - 1) :
    (nxt_phase == ST_DATA)  ? FIELD_CNT_W'(DATA_W - 1) : '0;
  wire [FIELD_CNT_W-1:0] nxt_cnt = phase_moves ? field_len :
                                   counts_up   ? cnt_ff + 1'b1 : cnt_ff - 1'b1;

  // field capture enables, one per rising management clock edge
  wire op_done  = rise & (phase_ff == ST_OPCODE) & cnt_ff[0];
  wire phy_bit  = rise & (phase_ff == ST_PHYAD);
  wire phy_done = phy_bit & last_field;
  wire reg_bit  = rise & (phase_ff == ST_REGAD);
  wire [REG_ADDR_W-1:0] reg_now = {reg_ff[REG_ADDR_W-2:0], mdio_s};

  // phase and counters advance only on a rising management clock edge
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      phase_ff <= ST_PREAMBLE;
      ones_ff  <= '0;
      cnt_ff   <= '0;
      pair_ff  <= 2'h0;
    end
    else if (rise)
    begin
      phase_ff <= nxt_phase;
      ones_ff  <= nxt_ones;
      cnt_ff   <= nxt_cnt;
      pair_ff  <= pair_now;
    end
  end

  // captured fields; mine_ff is only looked at after it is refreshed
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      is_read_ff <= 1'b0;
      phy_ff     <= '0;
      reg_ff     <= '0;
      mine_ff    <= 1'b0;
    end
    else
    begin
      if (op_done)
        is_read_ff <= (pair_now == OP_READ);
      if (phy_bit)
        phy_ff <= phy_now;
      if (phy_done)
        mine_ff <= addr_hit;
      if (reg_bit)
        reg_ff <= reg_now;
    end
  end

  // ----------------------------------------------------------------
  // register side and data shifting
  // ----------------------------------------------------------------
  wire read_fetch = rise & mine_ff & is_read_ff & (phase_ff == ST_REGAD) & last_field;
  wire data_bit   = rise & (phase_ff == ST_DATA);
  wire commit     = rise & (phase_ff == ST_CLOSE) & mine_ff & ~is_read_ff;
  wire [DATA_W-1:0] shifted_word = is_read_ff ? {shift_ff[DATA_W-2:0], 1'b0} :
                                                {shift_ff[DATA_W-2:0], mdio_s};

  // read data is fetched one cycle after the strobe, at the start of turnaround
  logic load_pending_ff;

  // strobes are single-cycle pulses; the holder gives no answer back
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      reg_rd_strobe   <= 1'b0;
      reg_wr_strobe   <= 1'b0;
      load_pending_ff <= 1'b0;
    end
    else
    begin
      reg_rd_strobe   <= read_fetch;
      reg_wr_strobe   <= commit;
      load_pending_ff <= reg_rd_strobe;
    end
  end

  // address and write data hold until the next strobe
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      reg_addr    <= '0;
      reg_wr_data <= '0;
    end
    else
    begin
      if (read_fetch)
        reg_addr <= reg_now;
      else if (commit)
        reg_addr <= reg_ff;
      if (commit)
        reg_wr_data <= shift_ff;
    end
  end

  // a write shifts the line in; a read shifts zeros in behind the msb
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      shift_ff <= '0;
    else if (load_pending_ff)
      shift_ff <= reg_rd_data;
    else if (data_bit)
      shift_ff <= shifted_word;
  end

  // local copy of the skip bit, kept current by writes to its register
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      skip_ff <= 1'b0;
    else if (commit && skip_write)
      skip_ff <= shift_ff[SKIP_BIT];
  end

  // ----------------------------------------------------------------
  // data line drive
  // ----------------------------------------------------------------
  // drive begins after the rising edge that ends turnaround bit one and
  // stops at the edge after the last data bit: 17 bit times in all
  wire drive_win = mine_ff & is_read_ff &
                   (((phase_ff == ST_TURN) & cnt_ff[0]) | (phase_ff == ST_DATA));
  wire drive_val = (phase_ff == ST_DATA) ? shift_ff[DATA_W-1] : 1'b0;

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      mdio_out  <= 1'b1;
      mdio_oe_n <= 1'b1;
    end
    else
    begin
      mdio_oe_n <= ~drive_win;
      mdio_out  <= drive_win ? drive_val : 1'b1;
    end
  end

  // skip setting shown two cycles after the commit, one after skip_ff, from its own flop
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      preamble_skip_enable <= 1'b0;
    else
      preamble_skip_enable <= skip_ff;
  end

endmodule

// ---- verification/mgmt_ctl_model.sv ----
// station management controller model driving mdc and the data line
`timescale 1ns/10ps
module mgmt_ctl_model
  import mgmt_pkg::*;
(
  output logic      mdc,
  output logic      ctl_en,
  output logic      ctl_bit,
  input  wire logic line
);
  // ------
  // framing
  // ------
  // mdc stands low between frames
  initial
  begin
    mdc = 1'b0;
    ctl_en = 1'b0;
    ctl_bit = 1'b1;
  end
  // one bit per period: set in the low phase, sampled at the rise
  task automatic bit_time(input logic en, input logic b, output logic s);
    ctl_en = en;
    ctl_bit = b;
    #200 mdc = 1'b1;
    s = line;
    #200 mdc = 1'b0;
  endtask
  // got keeps the line level at the last 18 frame rises, before the two idle bits
  task automatic frame(input int npre, input logic [1:0] st, input logic [1:0] op,
                       input logic [4:0] phy, input logic [4:0] rg,
                       input logic [15:0] wd, output logic [17:0] got);
    logic [63:0] bits;
    logic        s;
    bits = {32'hffff_ffff, st, op, phy, rg, 2'h2, wd};
    got = 18'h0;
    for (int i = 32 - npre; i < 64; i++)
    begin
      bit_time(!(op == OP_READ && i > 45), bits[63 - i], s);
      got = {got[16:0], s};
    end
    bit_time(1'b0, 1'b1, s);
    bit_time(1'b0, 1'b1, s);
  endtask
endmodule

// ---- verification/phy_mdio_management_port_bench.sv ----
// bench: controller model sends frames, bench plays the register holder
`timescale 1ns/10ps
module phy_mdio_management_port_bench
  import mgmt_pkg::*;
;
  localparam logic [4:0] ME = 5'h1d;
  logic        ref_clk = 1'b0;
  logic        nrst, isolate, mdc, mdio_in, mdio_out, mdio_oe_n, ctl_en, ctl_bit;
  logic        reg_rd_strobe, reg_wr_strobe, preamble_skip_enable;
  logic [4:0]  reg_addr, rd_a, wr_a;
  logic [15:0] reg_rd_data, reg_wr_data, wr_d;
  logic [17:0] n_rd, n_wr, n_drv, n_clash;
  int          failures = 0;
  int          n_tests = 0;
  // ------
  // wiring
  // ------
  phy_mdio_management_port #(.OWN_ADDR(ME)) u_dut
  (
    .ref_clk, .nrst, .mdc, .mdio_in, .mdio_out, .mdio_oe_n, .isolate, .reg_rd_data,
    .reg_addr, .reg_rd_strobe, .reg_wr_data, .reg_wr_strobe, .preamble_skip_enable
  );
  mgmt_ctl_model u_ctl (.mdc, .ctl_en, .ctl_bit, .line(mdio_in));
  always #25 ref_clk = ~ref_clk;
  // device wins when enabled, else controller, else the pull-up
  assign mdio_in = !mdio_oe_n ? mdio_out : (ctl_en ? ctl_bit : 1'b1);
  // register holder: read data is ready the cycle after the strobe
  always @(negedge ref_clk)
  begin
    if (reg_rd_strobe === 1'b1)
    begin
      reg_rd_data <= 16'hc3a0 ^ {11'h0, reg_addr};
      rd_a <= reg_addr;
      n_rd <= n_rd + 18'h1;
    end
    if (reg_wr_strobe === 1'b1)
    begin
      {wr_a, wr_d} <= {reg_addr, reg_wr_data};
      n_wr <= n_wr + 18'h1;
    end
  end
  // count device-driven bits and clashes at each mdc rise
  always @(posedge mdc)
  begin
    n_drv += 18'(mdio_oe_n === 1'b0);
    n_clash += 18'(mdio_oe_n === 1'b0 && ctl_en === 1'b1);
  end
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic t_read(input logic [4:0] rg);
    logic [17:0] got;
    {n_rd, n_drv, n_clash} = 54'h0;
    u_ctl.frame(32, START_PATTERN, OP_READ, ME, rg, 16'h0, got);
    chk(got, {2'h2, 16'hc3a0 ^ {11'h0, rg}});
    chk(n_drv, 18'h11);
    chk(n_clash, 18'h0);
    chk(n_rd, 18'h1);
    chk(18'(rd_a), 18'(rg));
  endtask
  task automatic t_write(input logic [4:0] rg, input logic [15:0] d);
    logic [17:0] got;
    {n_wr, n_drv} = 36'h0;
    u_ctl.frame(32, START_PATTERN, OP_WRITE, ME, rg, d, got);
    chk(n_wr, 18'h1);
    chk(18'(wr_a), 18'(rg));
    chk(18'(wr_d), 18'(d));
    chk(n_drv, 18'h0);
  endtask
  // skip on: no ones needed; skip off: a short run is ignored
  task automatic t_skip;
    logic [17:0] got;
    // read first, then write back the read word with only bit 6 changed
    t_read(SKIP_REG_ADDR);
    t_write(SKIP_REG_ADDR, 16'hc3e1);
    chk(18'(preamble_skip_enable), 18'h1);
    u_ctl.frame(0, START_PATTERN, OP_READ, ME, 5'h02, 16'h0, got);
    chk(got, 18'h2c3a2);
    t_write(SKIP_REG_ADDR, 16'hc3a1);
    chk(18'(preamble_skip_enable), 18'h0);
    n_rd = 18'h0;
    u_ctl.frame(10, START_PATTERN, OP_READ, ME, 5'h02, 16'h0, got);
    chk(n_rd, 18'h0);
  endtask
  // other address, bad opcodes, bad start; isolated port still answers
  task automatic t_refuse;
    logic [17:0] got;
    @(negedge ref_clk) isolate = 1'b1;
    {n_rd, n_wr, n_drv} = 54'h0;
    u_ctl.frame(32, START_PATTERN, OP_READ, ME + 5'h01, 5'h03, 16'h0, got);
    chk(n_drv, 18'h0);
    u_ctl.frame(32, START_PATTERN, 2'h0, ME, 5'h03, 16'h1234, got);
    u_ctl.frame(32, START_PATTERN, 2'h3, ME, 5'h03, 16'h1234, got);
    u_ctl.frame(32, 2'h0, OP_WRITE, ME, 5'h03, 16'h1234, got);
    chk(n_rd + n_wr, 18'h0);
    t_read(5'h05);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    {nrst, isolate, reg_rd_data} = 18'h0;
    repeat (16) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_read(5'h1f);
    t_read(5'h00);
    t_write(5'h1f, 16'h8001);
    t_skip;
    t_refuse;
    test_done;
  end
  // hang guard
  initial
  begin
    #2000000;
    failures++;
    test_done;
  end
endmodule
bind phy_mdio_management_port phy_mdio_management_port_monitor u_mon
(
  .ref_clk, .nrst, .mdc, .mdio_out, .mdio_oe_n, .reg_addr, .reg_rd_strobe,
  .reg_wr_data, .reg_wr_strobe, .preamble_skip_enable
);

// ---- verification/phy_mdio_management_port_monitor.sv ----
// checker on the management port pins
`timescale 1ns/10ps
module phy_mdio_management_port_monitor
  import mgmt_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        mdc,
  input wire logic        mdio_out,
  input wire logic        mdio_oe_n,
  input wire logic [4:0]  reg_addr,
  input wire logic        reg_rd_strobe,
  input wire logic [15:0] reg_wr_data,
  input wire logic        reg_wr_strobe,
  input wire logic        preamble_skip_enable
);
  // ------
  // helpers
  // ------
  logic [7:0] age_ff;
  logic [7:0] low_ff;
  logic       mdc_ff;
  // age saturates so a long idle never wraps back into the window
  always_ff @(posedge ref_clk)
  begin
    mdc_ff <= mdc;
    age_ff <= (mdc && !mdc_ff) ? 8'h00 : age_ff + 8'(age_ff != 8'hff);
    low_ff <= mdio_oe_n ? 8'h00 : low_ff + 8'h01;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_rd_pulse: assert property (reg_rd_strobe |=> !reg_rd_strobe)
    else $error("read strobe too long");
  a_wr_pulse: assert property (reg_wr_strobe |=> !reg_wr_strobe)
    else $error("write strobe too long");
  a_ta_low: assert property ($fell(mdio_oe_n) |-> !mdio_out)
    else $error("second turnaround bit not low");
  a_first_ta_free: assert property (reg_rd_strobe |-> mdio_oe_n[*5] ##[1:5] $fell(mdio_oe_n))
    else $error("drive start off");
  a_bit_timing: assert property (!mdio_oe_n && $changed(mdio_out) |-> age_ff inside {[2:7]})
    else $error("data changed away from mdc rise");
  a_drive_len: assert property ($rose(mdio_oe_n) |-> low_ff inside {[134:138]})
    else $error("drive length not 17 bits");
  a_reset_idle: assert property (!$past(nrst) |-> mdio_oe_n && !reg_wr_strobe)
    else $error("port not idle after reset");
  a_skip_follow: assert property ($changed(preamble_skip_enable) |->
    reg_addr == SKIP_REG_ADDR && preamble_skip_enable == reg_wr_data[SKIP_BIT])
    else $error("skip setting changed without write");
  c_read: cover property (reg_rd_strobe);
  c_write: cover property (reg_wr_strobe);
  c_skip: cover property ($rose(preamble_skip_enable));
endmodule
